/* File: vpdr_page_responder.v */
// AXI4-Lite front end that answers inquiry requests with page images
`timescale 1ns/10ps
`include "vpdr_defines.vh"

// Function
// - Vital-data bit set selects page by code
// - Byte 0 holds type 1Eh, qualifier 0
// - Byte 1 echoes the requested page code
// - Bytes 2-3 give following byte count
// - Supported list: seven codes ascending, length 07h
// - Serial page 80h, length 4, ASCII
// - Identification page 83h, descriptor header fixed
// - Descriptor identical on every access path
// - Protocol-identifier-valid flag cleared
// - Designator length 8, company and extension
// - Policy page 87h, 4-byte descriptors
// - Three policy descriptors with given codes
// - Block limits B0h, compare-write length zero
// - Optimal granularity and length are 20h
// - Maximum transfer length reported as zero
// - Maximum prefetch length is 100h blocks
// - Maximum unmap count all ones
// - Cleared bit, code zero: standard data
module vpdr_page_responder #(
  parameter [31:0] SERIAL_INIT = 32'h30303031, // Arbitrary default serial
  parameter [31:0] IDHI_INIT   = 32'h00000000, // Arbitrary company id
  parameter [31:0] IDLO_INIT   = 32'h00000000  // Arbitrary extension id
) (
  input  wire        clk,          // 10 MHz clock
  input  wire        rst_b,        // Sync reset, active low
  input  wire [7:0]  s_axi_awaddr, // Write address
  input  wire        s_axi_awvalid,// Write address valid
  output reg         s_axi_awready,// Write address ready
  input  wire [31:0] s_axi_wdata,  // Write data
  input  wire [3:0]  s_axi_wstrb,  // Write strobes
  input  wire        s_axi_wvalid, // Write data valid
  output reg         s_axi_wready, // Write data ready
  output reg  [1:0]  s_axi_bresp,  // Write response
  output reg         s_axi_bvalid, // Write response valid
  input  wire        s_axi_bready, // Write response ready
  input  wire [7:0]  s_axi_araddr, // Read address
  input  wire        s_axi_arvalid,// Read address valid
  output reg         s_axi_arready,// Read address ready
  output reg  [31:0] s_axi_rdata,  // Read data
  output reg  [1:0]  s_axi_rresp,  // Read response
  output reg         s_axi_rvalid, // Read data valid
  input  wire        s_axi_rready  // Read data ready
);

  localparam [1:0] W_IDLE = 2'h0;
  localparam [1:0] W_RESP = 2'h1;

  reg  [1:0]  wState_reg;
  reg  [7:0]  awAddr_reg;
  reg         awHave_reg;
  reg  [31:0] wData_reg;
  reg  [3:0]  wStrb_reg;
  reg         wHave_reg;
  reg  [7:0]  pageCode_reg;
  reg         evpd_reg;
  reg  [1:0]  status_reg;
  reg  [5:0]  rdPtr_reg;
  reg  [31:0] serial_reg;
  reg  [31:0] idHi_reg;
  reg  [31:0] idLo_reg;
  reg  [7:0]  idExt_reg;
  wire [7:0]  pageByte;
  wire        pageKnown;
  wire [15:0] pageLen;
  reg  [5:0]  romIdx;
  reg  [31:0] rdWord;
  reg         rdOk;
  reg  [7:0]  rdAddr_reg;
  reg         rdPend_reg;

  // Merge strobed bytes into an existing word
  function [31:0] strobeMerge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    integer      i;
    begin
      strobeMerge = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i])
          strobeMerge[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
  endfunction

  // One byte of the current page per read of the data window
  vpdr_page_rom uRom (
    .pageCode  (pageCode_reg),
    .byteIdx   (romIdx),
    .serialNum (serial_reg),
    .companyId (idHi_reg[23:0]),
    .extId     ({idLo_reg, idExt_reg}),
    .pageByte  (pageByte),
    .pageKnown (pageKnown),
    .pageLen   (pageLen)
  );

  always @* begin
    romIdx = rdPtr_reg;
  end

  // Write channel: address and data captured in either order
  always @(posedge clk) begin
    if (!rst_b) begin
      wState_reg    <= W_IDLE;
      awHave_reg    <= 1'b0;
      wHave_reg     <= 1'b0;
      awAddr_reg    <= 8'h00;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      pageCode_reg  <= `VPDR_PG_SUPPORTED;
      evpd_reg      <= 1'b0;
      status_reg    <= 2'h0;
      serial_reg    <= SERIAL_INIT;
      idHi_reg      <= IDHI_INIT;
      idLo_reg      <= IDLO_INIT;
      idExt_reg     <= 8'h00;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wState_reg)
        W_IDLE: begin
          if (s_axi_awvalid && !awHave_reg && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
          end
          if (s_axi_awvalid && s_axi_awready) begin
            awAddr_reg <= s_axi_awaddr;
            awHave_reg <= 1'b1;
          end
          if (s_axi_wvalid && !wHave_reg && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
            wHave_reg <= 1'b1;
          end
          if (awHave_reg && wHave_reg) begin
            awHave_reg   <= 1'b0;
            wHave_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            wState_reg   <= W_RESP;
            case (awAddr_reg & 8'hFC)
              `VPDR_OFS_CMD: begin
                if (wStrb_reg[0])
                  pageCode_reg <= wData_reg[`VPDR_CMD_PAGE_LSB +: 8];
                if (wStrb_reg[1])
                  evpd_reg <= wData_reg[`VPDR_CMD_EVPD_BIT];
                // A new command rewinds the page and grades the request
                if (wStrb_reg[0] || wStrb_reg[1])
                  status_reg <= 2'h0;
              end
              `VPDR_OFS_SERIAL: serial_reg <= strobeMerge(serial_reg, wData_reg, wStrb_reg);
              `VPDR_OFS_IDHI:   idHi_reg   <= strobeMerge(idHi_reg, wData_reg, wStrb_reg);
              `VPDR_OFS_IDLO:   idLo_reg   <= strobeMerge(idLo_reg, wData_reg, wStrb_reg);
              `VPDR_OFS_IDEXT:  idExt_reg  <= wStrb_reg[0] ? wData_reg[7:0] : idExt_reg;
              `VPDR_OFS_STATUS, `VPDR_OFS_RDPTR, `VPDR_OFS_DATA: s_axi_bresp <= 2'h0;
              default: s_axi_bresp <= 2'h2;
            endcase
          end else if (status_reg == 2'h0) begin
            if (evpd_reg && pageKnown)
              status_reg <= `VPDR_ST_VPD;
            else if (!evpd_reg && pageCode_reg == 8'h00)
              status_reg <= `VPDR_ST_STD;
            else
              status_reg <= `VPDR_ST_BAD;
          end
        end
        W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wState_reg   <= W_IDLE;
          end
        end
        default: wState_reg <= W_IDLE;
      endcase
    end
  end

  // Read decode; data window only yields page bytes for a valid VPD request
  always @* begin
    rdOk   = 1'b1;
    rdWord = 32'h00000000;
    case (rdAddr_reg & 8'hFC)
      `VPDR_OFS_CMD:    rdWord = {23'h000000, evpd_reg, pageCode_reg};
      `VPDR_OFS_STATUS: rdWord = {14'h0000, pageLen, status_reg};
      `VPDR_OFS_RDPTR:  rdWord = {26'h0000000, rdPtr_reg};
      `VPDR_OFS_DATA:   rdWord = (status_reg == `VPDR_ST_VPD) ? {24'h000000, pageByte} : 32'h00000000;
      `VPDR_OFS_SERIAL: rdWord = serial_reg;
      `VPDR_OFS_IDHI:   rdWord = {8'h00, idHi_reg[23:0]};
      `VPDR_OFS_IDLO:   rdWord = idLo_reg;
      `VPDR_OFS_IDEXT:  rdWord = {24'h000000, idExt_reg};
      default:          rdOk = 1'b0;
    endcase
  end

  // Read channel; each read of the data window advances the byte pointer until it reaches 3Fh
  always @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
      rdAddr_reg    <= 8'h00;
      rdPend_reg    <= 1'b0;
      rdPtr_reg     <= 6'h00;
    end else begin
      s_axi_arready <= 1'b0;
      if (!rdPend_reg && !s_axi_rvalid && s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rdAddr_reg <= s_axi_araddr;
        rdPend_reg <= 1'b1;
      end
      if (rdPend_reg) begin
        rdPend_reg   <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdWord;
        s_axi_rresp  <= rdOk ? 2'h0 : 2'h2;
        // Pointer stops at the last byte so over-reads return zero padding
        if ((rdAddr_reg & 8'hFC) == `VPDR_OFS_DATA && rdPtr_reg != 6'h3F)
          rdPtr_reg <= rdPtr_reg + 6'h01;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // Rewind comes last so a new command wins over a data read in the same cycle
      if (s_axi_awvalid && s_axi_awready && (s_axi_awaddr & 8'hFC) == `VPDR_OFS_CMD) begin
        rdPtr_reg <= 6'h00;
      end
    end
  end

endmodule

/* File: vpdr_defines.vh */
// Constants for the vital product data page responder
`ifndef VPDR_DEFINES_VH
`define VPDR_DEFINES_VH

// AXI4-Lite register byte offsets
`define VPDR_OFS_CMD      8'h00
`define VPDR_OFS_STATUS   8'h04
`define VPDR_OFS_RDPTR    8'h08
`define VPDR_OFS_DATA     8'h0C
`define VPDR_OFS_SERIAL   8'h10
`define VPDR_OFS_IDHI     8'h14
`define VPDR_OFS_IDLO     8'h18
`define VPDR_OFS_IDEXT    8'h1C

// Command register fields
`define VPDR_CMD_PAGE_LSB 0
`define VPDR_CMD_EVPD_BIT 8

// Byte 0 of every page
`define VPDR_PDT          5'h1E
`define VPDR_PQUAL        3'h0

// Page codes
`define VPDR_PG_SUPPORTED 8'h00
`define VPDR_PG_SERIAL    8'h80
`define VPDR_PG_DEVID     8'h83
`define VPDR_PG_POLICY    8'h87
`define VPDR_PG_LIMITS    8'hB0
`define VPDR_PG_CHAR      8'hB1
`define VPDR_PG_PROV      8'hB2

// Page lengths
`define VPDR_LEN_SUPPORTED 16'h0007
`define VPDR_LEN_SERIAL    16'h0004
`define VPDR_LEN_DEVID     16'h000C
`define VPDR_LEN_POLICY    16'h000C
`define VPDR_LEN_LIMITS    16'h003C

// Identification descriptor header
`define VPDR_CODE_SET     5'h2
`define VPDR_PROTO_ID     3'h0
`define VPDR_DESIG_TYPE   4'h1
`define VPDR_ASSOC        2'h0
`define VPDR_DESIG_LEN    8'h08

// Block limits values
`define VPDR_MAX_CAW      8'h00
`define VPDR_OPT_GRAN     16'h0020
`define VPDR_MAX_XFER     32'h00000000
`define VPDR_OPT_XFER     32'h00000020
`define VPDR_MAX_PREFETCH 32'h00000100
`define VPDR_MAX_UNMAP    32'hFFFFFFFF

// Response status codes
`define VPDR_ST_VPD       2'h1
`define VPDR_ST_STD       2'h2
`define VPDR_ST_BAD       2'h3

`endif

/* File: vpdr_page_rom.v */
// Byte image generator for the vital product data pages
`timescale 1ns/10ps
`include "vpdr_defines.vh"

module vpdr_page_rom (
  input  wire [7:0]  pageCode,   // Selected page code
  input  wire [5:0]  byteIdx,    // Byte index in the page
  input  wire [31:0] serialNum,  // Four ASCII serial characters
  input  wire [23:0] companyId,  // Company identifier
  input  wire [39:0] extId,      // Vendor extension identifier
  output reg  [7:0]  pageByte,   // Byte value at byteIdx
  output reg         pageKnown,  // Page code is implemented
  output reg  [15:0] pageLen     // Page length field
);

  // Policy descriptors are 4 bytes each: code, subpage, flags, reserved
  function [7:0] policyByte;
    input [4:0] off;
    reg   [2:0] d;
    begin
      d = off[4:2];
      policyByte = 8'h00;
      case (off[1:0])
        2'h0: begin
          case (d)
            3'h0: policyByte = 8'h01;
            3'h1: policyByte = 8'h08;
            3'h2: policyByte = 8'h0A;
            default: policyByte = 8'h3F;
          endcase
        end
        2'h1: policyByte = (d == 3'h4) ? 8'hFF : 8'h00;
        2'h2: policyByte = (d < 3'h2) ? 8'h80 : 8'h00;
        default: policyByte = 8'h00;
      endcase
    end
  endfunction

  // One byte of a 32-bit field, byte 3 being the most significant
  function [7:0] fieldByte;
    input [31:0] val;
    input [1:0]  sel;
    begin
      fieldByte = val[sel*8 +: 8];
    end
  endfunction

  always @* begin
    pageKnown = 1'b1;
    pageLen   = 16'h0000;
    pageByte  = 8'h00;
    case (pageCode)
      `VPDR_PG_SUPPORTED: pageLen = `VPDR_LEN_SUPPORTED;
      `VPDR_PG_SERIAL:    pageLen = `VPDR_LEN_SERIAL;
      `VPDR_PG_DEVID:     pageLen = `VPDR_LEN_DEVID;
      `VPDR_PG_POLICY:    pageLen = `VPDR_LEN_POLICY;
      `VPDR_PG_LIMITS:    pageLen = `VPDR_LEN_LIMITS;
      default:            pageKnown = 1'b0;
    endcase
    // Common header, MSB first
    if (byteIdx == 6'h00)
      pageByte = {`VPDR_PQUAL, `VPDR_PDT};
    else if (byteIdx == 6'h01)
      pageByte = pageCode;
    else if (byteIdx == 6'h02)
      pageByte = pageLen[15:8];
    else if (byteIdx == 6'h03)
      pageByte = pageLen[7:0];
    else if ({10'h000, byteIdx} < pageLen + 16'h0004) begin
      case (pageCode)
        `VPDR_PG_SUPPORTED: begin
          case (byteIdx)
            6'h05: pageByte = `VPDR_PG_SERIAL;
            6'h06: pageByte = `VPDR_PG_DEVID;
            6'h07: pageByte = `VPDR_PG_POLICY;
            6'h08: pageByte = `VPDR_PG_LIMITS;
            6'h09: pageByte = `VPDR_PG_CHAR;
            6'h0A: pageByte = `VPDR_PG_PROV;
            default: pageByte = `VPDR_PG_SUPPORTED;
          endcase
        end
        `VPDR_PG_SERIAL: begin
          case (byteIdx)
            6'h04: pageByte = serialNum[31:24];
            6'h05: pageByte = serialNum[23:16];
            6'h06: pageByte = serialNum[15:8];
            default: pageByte = serialNum[7:0];
          endcase
        end
        `VPDR_PG_DEVID: begin
          // Descriptor has no path input, only the id registers, so every path sees the same image
          case (byteIdx)
            6'h04: pageByte = {`VPDR_PROTO_ID, `VPDR_CODE_SET};
            6'h05: pageByte = {1'b0, 1'b0, `VPDR_ASSOC, `VPDR_DESIG_TYPE};
            6'h07: pageByte = `VPDR_DESIG_LEN;
            6'h08: pageByte = companyId[23:16];
            6'h09: pageByte = companyId[15:8];
            6'h0A: pageByte = companyId[7:0];
            6'h0B: pageByte = extId[39:32];
            6'h0C: pageByte = extId[31:24];
            6'h0D: pageByte = extId[23:16];
            6'h0E: pageByte = extId[15:8];
            6'h0F: pageByte = extId[7:0];
            default: pageByte = 8'h00;
          endcase
        end
        `VPDR_PG_POLICY:
          pageByte = policyByte(byteIdx[4:0] - 5'h04);
        `VPDR_PG_LIMITS: begin
          case (byteIdx)
            6'h05: pageByte = `VPDR_MAX_CAW;
            6'h06: pageByte = fieldByte({16'h0000, `VPDR_OPT_GRAN}, 2'h1);
            6'h07: pageByte = fieldByte({16'h0000, `VPDR_OPT_GRAN}, 2'h0);
            6'h08: pageByte = fieldByte(`VPDR_MAX_XFER, 2'h3);
            6'h09: pageByte = fieldByte(`VPDR_MAX_XFER, 2'h2);
            6'h0A: pageByte = fieldByte(`VPDR_MAX_XFER, 2'h1);
            6'h0B: pageByte = fieldByte(`VPDR_MAX_XFER, 2'h0);
            6'h0C: pageByte = fieldByte(`VPDR_OPT_XFER, 2'h3);
            6'h0D: pageByte = fieldByte(`VPDR_OPT_XFER, 2'h2);
            6'h0E: pageByte = fieldByte(`VPDR_OPT_XFER, 2'h1);
            6'h0F: pageByte = fieldByte(`VPDR_OPT_XFER, 2'h0);
            6'h10: pageByte = fieldByte(`VPDR_MAX_PREFETCH, 2'h3);
            6'h11: pageByte = fieldByte(`VPDR_MAX_PREFETCH, 2'h2);
            6'h12: pageByte = fieldByte(`VPDR_MAX_PREFETCH, 2'h1);
            6'h13: pageByte = fieldByte(`VPDR_MAX_PREFETCH, 2'h0);
            6'h14: pageByte = fieldByte(`VPDR_MAX_UNMAP, 2'h3);
            6'h15: pageByte = fieldByte(`VPDR_MAX_UNMAP, 2'h2);
            6'h16: pageByte = fieldByte(`VPDR_MAX_UNMAP, 2'h1);
            6'h17: pageByte = fieldByte(`VPDR_MAX_UNMAP, 2'h0);
            default: pageByte = 8'h00;
          endcase
        end
        default: pageByte = 8'h00;
      endcase
    end
  end

endmodule

/* File: vpdr_page_responder_properties.sv */
// Checker for the responder's AXI4-Lite port timing and answers
`timescale 1ns/10ps
`include "vpdr_defines.vh"
module vpdr_checker (
  input wire        clk,           // Clock
  input wire        rst_b,         // Reset, active low
  input wire        s_axi_awvalid, // AW valid
  input wire        s_axi_awready, // AW ready
  input wire        s_axi_wready,  // W ready
  input wire [1:0]  s_axi_bresp,   // B response
  input wire        s_axi_bvalid,  // B valid
  input wire        s_axi_bready,  // B ready
  input wire [7:0]  s_axi_araddr,  // AR address
  input wire        s_axi_arvalid, // AR valid
  input wire        s_axi_arready, // AR ready
  input wire [31:0] s_axi_rdata,   // Read data
  input wire [1:0]  s_axi_rresp,   // Read response
  input wire        s_axi_rvalid,  // R valid
  input wire        s_axi_rready   // R ready
);
  reg [7:0] rdAddr_reg;
  // Remembers which offset the pending answer belongs to
  always @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) rdAddr_reg <= s_axi_araddr;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  aw_gated_a: assert property (s_axi_awready |-> s_axi_awvalid)
    else $error("awready without awvalid");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  b_after_w_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wready, 2))
    else $error("bvalid not two cycles after wready");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_after_ar_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("rvalid late after address");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  r_from_ar_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready, 2))
    else $error("rvalid without address");
  bad_addr_a: assert property ($rose(s_axi_rvalid) && rdAddr_reg[7:2] > 6'h07 |-> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  good_addr_a: assert property ($rose(s_axi_rvalid) && rdAddr_reg[7:2] <= 6'h07 |-> s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  byte_lane_a: assert property ($rose(s_axi_rvalid) && rdAddr_reg[7:2] == 6'h03 |-> s_axi_rdata[31:8] == 24'h0)
    else $error("page byte upper bits set");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && rdAddr_reg == 8'h0C);
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
endmodule
bind vpdr_page_responder vpdr_checker vpdr_checker_i (.clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* File: vpdr_host_model.sv */
// Host controller model issuing inquiry requests over AXI4-Lite
`timescale 1ns/10ps
module vpdr_host_model (
  input  wire        clk,                   // Clock
  output reg  [7:0]  s_axi_awaddr  = 8'h00, // AW address
  output reg         s_axi_awvalid = 1'b0,  // AW valid
  input  wire        s_axi_awready,         // AW ready
  output reg  [31:0] s_axi_wdata   = 32'h0, // W data
  output reg  [3:0]  s_axi_wstrb   = 4'hF,  // W strobes
  output reg         s_axi_wvalid  = 1'b0,  // W valid
  input  wire        s_axi_wready,          // W ready
  input  wire [1:0]  s_axi_bresp,           // B response
  input  wire        s_axi_bvalid,          // B valid
  output reg         s_axi_bready  = 1'b0,  // B ready
  output reg  [7:0]  s_axi_araddr  = 8'h00, // AR address
  output reg         s_axi_arvalid = 1'b0,  // AR valid
  input  wire        s_axi_arready,         // AR ready
  input  wire [31:0] s_axi_rdata,           // R data
  input  wire [1:0]  s_axi_rresp,           // R response
  input  wire        s_axi_rvalid,          // R valid
  output reg         s_axi_rready  = 1'b0   // R ready
);
  // Released payloads flip so a stale value is never mistaken for a live one
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      // Ready comes a cycle late so the slave has to hold its answer
      s_axi_bready <= 1'b1;
      @(posedge clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      s_axi_awaddr <= ~a;
      s_axi_wdata <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      s_axi_araddr <= ~a;
    end
  endtask
endmodule

/* File: vpd_page_responder_bench.sv */
// Self-checking bench reading every page image through the register bus
`timescale 1ns/10ps
module vpd_page_responder_bench;
  localparam [31:0] SER = 32'h41375A39; // Arbitrary serial text
  localparam [31:0] IDH = 32'h00A1B2C3; // Arbitrary company id
  localparam [31:0] IDL = 32'h11223344; // Arbitrary extension id
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  wire [7:0]  s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  integer     failures = 0;
  integer     checks = 0;
  reg [31:0]  rv;
  reg [1:0]   rs;
  vpdr_page_responder #(.SERIAL_INIT(SER), .IDHI_INIT(IDH), .IDLO_INIT(IDL)) vpdr_page_responder_i (
    .clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  vpdr_host_model vpdr_host_model_i (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial forever #50 clk = ~clk;
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("Comparisons %0d, mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task bw(input [7:0] a, input [31:0] d);
    vpdr_host_model_i.wr(a, d, rs);
  endtask
  task br(input [7:0] a);
    vpdr_host_model_i.rd(a, rv, rs);
  endtask
  // Bytes 4 to 23 of each page; everything later in a page is zero
  function [7:0] expByte(input [7:0] pg, input [7:0] ln, input integer i);
    reg [159:0] body;
    begin
      case (pg)
        8'h00:   body = {56'h00_80_83_87_B0_B1_B2, 104'h0};
        8'h80:   body = {SER, 128'h0};
        8'h83:   body = {32'h02010008, IDH[23:0], IDL, 8'h55, 64'h0};
        8'h87:   body = {32'h01008000, 32'h08008000, 32'h0A000000, 64'h0};
        default: body = {32'h00000020, 32'h0, 32'h20, 32'h100, 32'hFFFFFFFF};
      endcase
      if (i == 0) expByte = 8'h1E;
      else if (i == 1) expByte = pg;
      else if (i == 2) expByte = 8'h00;
      else if (i == 3) expByte = ln;
      else if (i < 24) expByte = body[159 - 8 * (i - 4) -: 8];
      else expByte = 8'h00;
    end
  endfunction
  task page(input [7:0] pg, input [15:0] len);
    integer i;
    begin
      bw(8'h00, {23'h0, 1'b1, pg});
      check({30'h0, rs}, 32'h0);
      br(8'h04);
      check(rv, {14'h0, len, 2'h1});
      for (i = 0; i < len + 4; i = i + 1) begin
        br(8'h0C);
        check(rv, {24'h0, expByte(pg, len[7:0], i)});
      end
      br(8'h08);
      check(rv, (len > 16'h003B) ? 32'h3F : {16'h0, len} + 32'h4);
      $display("Page %h read", pg);
    end
  endtask
  task refusals;
    begin
      bw(8'h00, 32'h000001B1);
      br(8'h04);
      check({30'h0, rv[1:0]}, 32'h3);
      br(8'h0C);
      check(rv, 32'h0);
      check({30'h0, rs}, 32'h0);
      bw(8'h00, 32'h00000000);
      br(8'h04);
      check({30'h0, rv[1:0]}, 32'h2);
      br(8'h40);
      check({30'h0, rs}, 32'h2);
      bw(8'h40, 32'hFFFFFFFF);
      check({30'h0, rs}, 32'h2);
      $display("Refusal cases done");
    end
  endtask
  task reg_file;
    begin
      br(8'h10);
      check(rv, SER);
      br(8'h14);
      check(rv, {8'h00, IDH[23:0]});
      br(8'h18);
      check(rv, IDL);
      br(8'h1C);
      check(rv, 32'h00000055);
      bw(8'h10, 32'h39383736);
      br(8'h10);
      check(rv, 32'h39383736);
      bw(8'h10, SER);
      bw(8'h00, 32'h00000080);
      br(8'h00);
      check(rv, 32'h00000080);
      br(8'h04);
      check({30'h0, rv[1:0]}, 32'h3);
      $display("Register file done");
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bw(8'h1C, 32'h00000055);
    check({30'h0, rs}, 32'h0);
    page(8'h00, 16'h0007);
    page(8'h80, 16'h0004);
    page(8'h83, 16'h000C);
    page(8'h83, 16'h000C);
    page(8'h87, 16'h000C);
    page(8'hB0, 16'h003C);
    refusals;
    reg_file;
    tally_and_finish;
  end
  initial begin
    #(4000 * 100);
    failures = failures + 1;
    tally_and_finish;
  end
endmodule
